/* dv/isa_host_model.sv */
// Host side of the ISA bus issuing configuration port cycles
`timescale 1ns/1ps
`default_nettype none
module isa_host_model (
  input wire logic              clk_sys,
  output var ldcfg_pkg::isa_in_t isa_in
);
  initial isa_in = {16'h0000, 8'h00, 1'b0, 1'b1, 1'b1};

  // Strobe is held long enough for the two-flop synchroniser plus output flop
  task automatic access(input bit we, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    isa_in.addr <= a;
    isa_in.data <= d;
    @(posedge clk_sys);
    if (we) isa_in.iow_n <= 1'b0;
    else isa_in.ior_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    isa_in.iow_n <= 1'b1;
    isa_in.ior_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    // Released lines must not keep the last value
    isa_in.addr <= ~a;
    isa_in.data <= ~d;
  endtask : access
endmodule : isa_host_model
`default_nettype wire

/* dv/ldcfg_assertions.sv */
// Port checks for the logical device configuration bank
`timescale 1ns/1ps
`default_nettype none
module ldcfg_checker #(
  parameter logic [15:0] CFG_PORT = 16'h03F0
) (
  input wire logic               clk_sys,
  input wire logic               rst,
  input wire logic               soft_reset,
  input wire ldcfg_pkg::isa_in_t isa_in,
  input wire logic               config_state,
  input wire logic [5:0]         pwr_ctrl_wr,
  input wire logic [5:0]         pwr_ctrl_wdata,
  input wire logic               isa_data_oe_n,
  input wire logic [5:0]         dev_active,
  input wire logic [5:0]         dev_pwr_ctrl,
  input wire logic [5:0]         base_valid,
  input wire logic               par_epp_avail,
  input wire logic [7:0]         floppy_dma_sel,
  input wire logic               irq_active_high
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_bits_linked: assert property (dev_active == dev_pwr_ctrl)
    else $error("activate and power bits differ");
  a_irq_edge_high: assert property (irq_active_high)
    else $error("interrupt polarity not active high");
  a_fixed_not_valid: assert property (base_valid[5:4] == 2'b00)
    else $error("fixed device reports a valid base");
  a_power_write: assert property (pwr_ctrl_wr[0] && isa_in.iow_n
    |-> ##2 dev_active[0] == $past(pwr_ctrl_wdata[0], 2))
    else $error("power write did not reach activate state");
  a_epp_needs_base: assert property (par_epp_avail |-> base_valid[1])
    else $error("enhanced mode offered on illegal base");
  a_read_drive: assert property ($fell(isa_data_oe_n)
    |-> !$past(isa_in.ior_n, 2) && $past(isa_in.addr[15:1], 2) == CFG_PORT[15:1])
    else $error("data pins driven without config read");
  a_read_release: assert property ($rose(isa_in.ior_n) |-> ##[1:5] isa_data_oe_n)
    else $error("data pins not released after read");
  a_dma_by_write: assert property ($changed(floppy_dma_sel)
    |-> (!$past(isa_in.iow_n, 2) && $past(config_state, 2)) || $past(soft_reset)
        || $past(soft_reset, 2) || $past(rst) || $past(rst, 2))
    else $error("dma select changed without a write");

  c_read: cover property ($fell(isa_data_oe_n));
  c_power: cover property (pwr_ctrl_wr[0]);
  c_epp: cover property (par_epp_avail);
endmodule : ldcfg_checker

bind logical_device_config_regs ldcfg_checker #(.CFG_PORT(CFG_PORT)) chk (
  .clk_sys(clk_sys), .rst(rst), .soft_reset(soft_reset), .isa_in(isa_in),
  .config_state(config_state), .pwr_ctrl_wr(pwr_ctrl_wr), .pwr_ctrl_wdata(pwr_ctrl_wdata),
  .isa_data_oe_n(isa_data_oe_n), .dev_active(dev_active), .dev_pwr_ctrl(dev_pwr_ctrl),
  .base_valid(base_valid), .par_epp_avail(par_epp_avail), .floppy_dma_sel(floppy_dma_sel),
  .irq_active_high(irq_active_high));
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the logical device configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ldcfg_pkg::*;
  localparam logic [15:0] CFG = 16'h03F0;
  logic             clk_sys, rst, soft_reset, config_state, qual16_en, oe_prev;
  logic [5:0]       pwr_ctrl_wr, pwr_ctrl_wdata, dev_active, dev_pwr_ctrl, base_valid, dev_sel;
  isa_in_t          isa_in;
  logic [7:0]       isa_data_out, kbd_irq2_sel, floppy_dma_sel, par_dma_sel, v, e;
  logic             isa_data_oe_n, par_ext_sel, par_epp_avail, irq_active_high;
  logic [5:0][7:0]  irq_level_sel;
  logic [7:0]       exp_q[$];
  logic [31:0]      lfsr = 32'd94303;
  int               mismatches, n_tests;
  logic [7:0]       ldn_l[6] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08};
  logic [7:0]       idx_l[10] = '{8'h70, 8'h72, 8'h74, 8'h71, 8'h73, 8'h75, 8'h76, 8'hA8,
                                  8'hA9, 8'hDF};
  int               bsl[8] = '{0, 0, 0, 0, 1, 1, 2, 3};
  logic [15:0]      bad[8] = '{16'h0FF8, 16'h0FF9, 16'h00F8, 16'h1000, 16'h0FFC, 16'h0378,
                               16'h0100, 16'h0104};
  logic [7:0]       bv[8] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};

  logical_device_config_regs #(.CFG_PORT(CFG)) uut (
    .clk_sys(clk_sys), .rst(rst), .soft_reset(soft_reset), .isa_in(isa_in),
    .config_state(config_state), .qual16_en(qual16_en), .pwr_ctrl_wr(pwr_ctrl_wr),
    .pwr_ctrl_wdata(pwr_ctrl_wdata), .isa_data_out(isa_data_out),
    .isa_data_oe_n(isa_data_oe_n), .dev_active(dev_active), .dev_pwr_ctrl(dev_pwr_ctrl),
    .base_valid(base_valid), .dev_sel(dev_sel), .par_ext_sel(par_ext_sel),
    .par_epp_avail(par_epp_avail), .irq_level_sel(irq_level_sel),
    .kbd_irq2_sel(kbd_irq2_sel), .floppy_dma_sel(floppy_dma_sel),
    .par_dma_sel(par_dma_sel), .irq_active_high(irq_active_high));
  isa_host_model host (.clk_sys(clk_sys), .isa_in(isa_in));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction : rnd

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    host.access(1'b1, CFG, idx);
    host.access(1'b1, CFG + 16'h0001, d);
  endtask : wr

  // Expected byte is queued before the strobe; the monitor pairs it with the drive
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    host.access(1'b1, CFG, idx);
    exp_q.push_back(exp);
    host.access(1'b0, CFG + 16'h0001, 8'h00);
  endtask : rd

  // Host read at a device address; the selects stand while the synchronised strobe is low
  task automatic probe(input logic [15:0] a, input logic [6:0] exp);
    fork
      host.access(1'b0, a, 8'h00);
      begin
        repeat (6) @(posedge clk_sys);
        chk8({1'b0, par_ext_sel, dev_sel}, {1'b0, exp});
      end
    join
  endtask : probe

  task automatic stop_test();
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  always @(posedge clk_sys) begin
    if (oe_prev === 1'b1 && isa_data_oe_n === 1'b0) begin
      if (exp_q.size() > 0) chk8(isa_data_out, exp_q.pop_front());
      else begin
        mismatches++;
        $display("mismatch at %0t: unexpected read drive", $time);
      end
    end
    oe_prev <= isa_data_oe_n;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    soft_reset = 1'b0;
    config_state = 1'b1;
    qual16_en = 1'b0;
    pwr_ctrl_wr = 6'h00;
    pwr_ctrl_wdata = 6'h00;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk8(irq_level_sel[0], 8'h06);
    chk8(floppy_dma_sel, 8'h02);
    chk8(par_dma_sel, 8'h04);
    chk8({7'h00, irq_active_high}, 8'h01);
    for (int i = 0; i < 6; i++) begin
      wr(8'h07, ldn_l[i]);
      rd(8'h70, i == 0 ? 8'h06 : 8'h00);
      rd(8'h72, 8'h00);
      rd(8'h74, i == 0 ? 8'h02 : (i == 1 ? 8'h04 : 8'h00));
      v = rnd();
      for (int k = 0; k < 10; k++) wr(idx_l[k], v);
      for (int k = 0; k < 10; k++) begin
        e = (k == 0 || (k == 1 && i == 4) || (k == 2 && i < 2)) ? v : 8'h00;
        rd(idx_l[k], e);
      end
      chk8(irq_level_sel[i], v);
      if (i == 4) chk8(kbd_irq2_sel, v);
      if (i < 2) chk8(i == 0 ? floppy_dma_sel : par_dma_sel, v);
    end
    // Outside the configuration state even the index write must be dropped
    config_state <= 1'b0;
    wr(8'h70, ~v);
    config_state <= 1'b1;
    rd(8'h70, v);
    wr(8'h07, 8'h00);
    wr(8'h30, 8'h01);
    chk8({7'h00, dev_active[0]}, 8'h01);
    chk8({7'h00, dev_pwr_ctrl[0]}, 8'h01);
    @(posedge clk_sys);
    pwr_ctrl_wr <= 6'h01;
    @(posedge clk_sys);
    pwr_ctrl_wr <= 6'h00;
    repeat (3) @(posedge clk_sys);
    chk8({7'h00, dev_active[0]}, 8'h00);
    rd(8'h30, 8'h00);
    for (int j = 0; j < 8; j++) begin
      wr(8'h07, ldn_l[bsl[j]]);
      wr(8'h60, bad[j][15:8]);
      wr(8'h61, bad[j][7:0]);
      chk8({7'h00, base_valid[bsl[j]]}, bv[j]);
      if (bsl[j] == 1) chk8({7'h00, par_epp_avail}, {7'h00, ~bad[j][2]});
      rd(8'h60, bad[j][15:8]);
    end
    // Parallel at 0x378, serial 1 at 0x100, floppy at the illegal 0x1000
    wr(8'h07, 8'h03);
    wr(8'h30, 8'h01);
    probe(16'h037F, 7'h02);
    probe(16'h0380, 7'h00);
    probe(16'h077A, 7'h40);
    probe(16'h137A, 7'h02);
    qual16_en <= 1'b1;
    probe(16'h137A, 7'h00);
    qual16_en <= 1'b0;
    wr(8'h07, 8'h04);
    wr(8'h30, 8'h01);
    probe(16'h0107, 7'h04);
    wr(8'h07, 8'h00);
    wr(8'h30, 8'h01);
    probe(16'h1000, 7'h00);
    @(posedge clk_sys);
    soft_reset <= 1'b1;
    @(posedge clk_sys);
    soft_reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk8(irq_level_sel[0], 8'h06);
    chk8(kbd_irq2_sel, 8'h00);
    chk8(floppy_dma_sel, 8'h02);
    chk8(par_dma_sel, 8'h04);
    rd(8'h74, 8'h02);
    repeat (20) @(posedge clk_sys);
    chk8(8'(exp_q.size()), 8'h00);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire

/* hdl/base_addr_check.sv */
// Legality check and address decode for one relocatable device base
`timescale 1ns/1ps
`default_nettype none
module base_addr_check #(
  parameter logic [15:0] MAX_BASE  = 16'h0FF8,
  parameter int          ALIGN     = 3,
  parameter bit          HAS_EXT   = 1'b0
) (
  input  wire logic [15:0] base,
  input  wire logic [15:0] addr,
  input  wire logic        qual16,
  output logic             valid,
  output logic             hit,
  output logic             ext_hit,
  output logic             epp_ok
);
  import ldcfg_pkg::*;

  logic [11:0] ofs;
  logic        upper_ok;

  // Offset wraps modulo 4 KiB, so a plain unsigned compare finds the window
  assign ofs      = addr[11:0] - base[11:0];
  assign upper_ok = !qual16 || (addr[15:12] == 4'h0);
  assign valid    = (base >= BASE_MIN) && (base <= MAX_BASE)
                    && (base[ALIGN-1:0] == '0);
  // A parallel base that is not 8-byte aligned only decodes four offsets
  assign hit      = upper_ok && (base[2:0] == 3'h0 ? ofs < 12'h008 : ofs < 12'h004);
  assign ext_hit  = HAS_EXT && upper_ok
                    && (ofs >= EXT_OFS_FIRST) && (ofs <= EXT_OFS_LAST);
  assign epp_ok   = (base[2:0] == 3'h0);
endmodule : base_addr_check
`default_nettype wire

/* hdl/ldcfg_pkg.sv */
// Constants and carrier types for the logical device configuration bank
package ldcfg_pkg;

  localparam int NUM_SLOTS     = 6;
  localparam int SLOT_FLOPPY   = 0;
  localparam int SLOT_PARALLEL = 1;
  localparam int SLOT_SERIAL1  = 2;
  localparam int SLOT_SERIAL2  = 3;
  localparam int SLOT_KEYBOARD = 4;
  localparam int SLOT_AUX      = 5;

  // Logical device numbers as written to the device number register
  localparam logic [7:0] LDN_FLOPPY   = 8'h00;
  localparam logic [7:0] LDN_PARALLEL = 8'h03;
  localparam logic [7:0] LDN_SERIAL1  = 8'h04;
  localparam logic [7:0] LDN_SERIAL2  = 8'h05;
  localparam logic [7:0] LDN_KEYBOARD = 8'h07;
  localparam logic [7:0] LDN_AUX      = 8'h08;

  // Configuration indices
  localparam logic [7:0] IDX_LDN      = 8'h07;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_BASE_HI  = 8'h60;
  localparam logic [7:0] IDX_BASE_LO  = 8'h61;
  localparam logic [7:0] IDX_IRQ0     = 8'h70;
  localparam logic [7:0] IDX_IRQ1     = 8'h72;
  localparam logic [7:0] IDX_DMA      = 8'h74;
  localparam logic [7:0] IDX_BANK_LO  = 8'h30;
  localparam int         ACTIVATE_BIT = 0;

  // Reset values
  localparam logic [7:0] LDN_RST          = 8'h00;
  localparam logic [7:0] INDEX_RST        = 8'h00;
  localparam logic [7:0] BASE_RST         = 8'h00;
  localparam logic [7:0] IRQ0_RST_FLOPPY  = 8'h06;
  localparam logic [7:0] IRQ0_RST_OTHER   = 8'h00;
  localparam logic [7:0] IRQ1_RST         = 8'h00;
  localparam logic [7:0] DMA_RST_FLOPPY   = 8'h02;
  localparam logic [7:0] DMA_RST_PARALLEL = 8'h04;
  localparam logic [7:0] DMA_RST_OTHER    = 8'h00;
  localparam logic [7:0] READ_ZERO        = 8'h00;

  // Base address legality and decode
  localparam logic [15:0] BASE_MIN      = 16'h0100;
  localparam logic [15:0] BASE_MAX_8    = 16'h0FF8;
  localparam logic [15:0] BASE_MAX_PAR  = 16'h0FFC;
  localparam int          ALIGN_8       = 3;
  localparam int          ALIGN_4       = 2;
  localparam logic [11:0] EXT_OFS_FIRST = 12'h400;
  localparam logic [11:0] EXT_OFS_LAST  = 12'h402;
  localparam logic [15:0] CFG_PORT_DEFAULT = 16'h03F0;

  // ISA host pins as sampled together
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        aen;
    logic        ior_n;
    logic        iow_n;
  } isa_in_t;

endpackage : ldcfg_pkg

/* hdl/logical_device_config_regs.sv */
// Per logical device configuration bank behind the index and data ports
//
// Overview of operation
// - Primary interrupt select at 0x70 per device
// - 0x72 keyboard only; elsewhere reads zero
// - Primary irq resets 0x06 floppy, else zero
// - Routed interrupts default to active-high edge
// - Unimplemented indices ignore writes, read zero
// - DMA select only floppy, parallel; 0x75 zero
// - DMA select resets 0x02 floppy, 0x04 parallel
// - Device on when activate or power bit
// - Writing either linked bit sets the other
// - Illegal base address blocks host register access
// - Floppy, serial: 0x100..0xFF8, 8-aligned, eight offsets
// - Parallel 4-aligned to 0xFFC; EPP needs 8
// - Parallel second group at base+400h..402h
// - 0x60/0x61 hold base bits 15:8, 7:0
// - Index 0x30 bit 0 activates selected device
// - Index 0x07 selects the per-device bank
// - Decode uses A11:A0, A15:A12 zero if qualified
`timescale 1ns/1ps
`default_nettype none
module logical_device_config_regs #(
  parameter logic [15:0] CFG_PORT = 16'h03F0
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire logic                      soft_reset,
  input  wire ldcfg_pkg::isa_in_t        isa_in,
  input  wire logic                      config_state,
  input  wire logic                      qual16_en,
  input  wire logic [5:0]                pwr_ctrl_wr,
  input  wire logic [5:0]                pwr_ctrl_wdata,
  output logic [7:0]                     isa_data_out,
  output logic                           isa_data_oe_n,
  output logic [5:0]                     dev_active,
  output logic [5:0]                     dev_pwr_ctrl,
  output logic [5:0]                     base_valid,
  output logic [5:0]                     dev_sel,
  output logic                           par_ext_sel,
  output logic                           par_epp_avail,
  output logic [5:0][7:0]                irq_level_sel,
  output logic [7:0]                     kbd_irq2_sel,
  output logic [7:0]                     floppy_dma_sel,
  output logic [7:0]                     par_dma_sel,
  output logic                           irq_active_high
);
  import ldcfg_pkg::*;

  isa_in_t                isa_s1;
  isa_in_t                isa_s2;
  logic                   iow_prev;
  logic [7:0]             index;
  logic [7:0]             ldn;
  logic [5:0]             dev_on;
  logic [5:0][7:0]        base_hi;
  logic [5:0][7:0]        base_lo;
  logic [5:0][7:0]        irq0;
  logic [5:0][7:0]        dma;
  logic [7:0]             irq1;
  logic [5:0]             chk_valid;
  logic [5:0]             chk_hit;
  logic                   chk_ext;
  logic                   chk_epp;
  logic                   cyc_active;
  logic                   hit_index;
  logic                   hit_data;
  logic                   write_strobe;
  logic                   wr_data;
  logic [5:0]             slot_onehot;
  logic                   slot_known;
  logic [2:0]             slot;
  logic [7:0]             next_rdata;

  // Host pins are asynchronous to clk_sys
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      isa_s1   <= '{addr: 16'h0000, data: 8'h00, aen: 1'b1, ior_n: 1'b1, iow_n: 1'b1};
      isa_s2   <= '{addr: 16'h0000, data: 8'h00, aen: 1'b1, ior_n: 1'b1, iow_n: 1'b1};
      iow_prev <= 1'b1;
    end else begin
      isa_s1   <= isa_in;
      isa_s2   <= isa_s1;
      iow_prev <= isa_s2.iow_n;
    end
  end

  assign cyc_active   = !isa_s2.aen && (!isa_s2.ior_n || !isa_s2.iow_n);
  assign hit_index    = !isa_s2.aen && (isa_s2.addr == CFG_PORT);
  assign hit_data     = !isa_s2.aen && (isa_s2.addr == CFG_PORT + 16'h0001);
  // One write per strobe, taken on the falling edge after synchronising
  assign write_strobe = iow_prev && !isa_s2.iow_n && config_state;
  assign wr_data      = write_strobe && hit_data;

  // Map the device number to a storage slot
  always_comb begin
    slot_known = 1'b1;
    slot       = 3'(SLOT_FLOPPY);
    case (ldn)
      LDN_FLOPPY:   slot = 3'(SLOT_FLOPPY);
      LDN_PARALLEL: slot = 3'(SLOT_PARALLEL);
      LDN_SERIAL1:  slot = 3'(SLOT_SERIAL1);
      LDN_SERIAL2:  slot = 3'(SLOT_SERIAL2);
      LDN_KEYBOARD: slot = 3'(SLOT_KEYBOARD);
      LDN_AUX:      slot = 3'(SLOT_AUX);
      default:      slot_known = 1'b0;
    endcase
  end

  // Bank writes land only at an index of 0x30 or above while the device number names a known device
  assign slot_onehot = (wr_data && slot_known && index >= IDX_BANK_LO)
                       ? 6'(6'h01 << slot) : 6'h00;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      index <= INDEX_RST;
    end else if (soft_reset) begin
      index <= INDEX_RST;
    end else if (write_strobe && hit_index) begin
      index <= isa_s2.data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ldn <= LDN_RST;
    end else if (soft_reset) begin
      ldn <= LDN_RST;
    end else if (wr_data && index == IDX_LDN) begin
      ldn <= isa_s2.data;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SLOTS; gi++) begin : g_slot
      localparam logic [7:0] IRQ0_RST = (gi == SLOT_FLOPPY) ? IRQ0_RST_FLOPPY
                                                            : IRQ0_RST_OTHER;
      localparam logic [7:0] DMA_RST  = (gi == SLOT_FLOPPY)   ? DMA_RST_FLOPPY :
                                        (gi == SLOT_PARALLEL) ? DMA_RST_PARALLEL
                                                              : DMA_RST_OTHER;
      localparam bit HAS_BASE = gi <= SLOT_SERIAL2;
      localparam bit HAS_DMA  = gi == SLOT_FLOPPY || gi == SLOT_PARALLEL;

      // Activate and power control share one flop, so they can never disagree
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          dev_on[gi] <= 1'b0;
        end else if (soft_reset) begin
          dev_on[gi] <= 1'b0;
        end else if (slot_onehot[gi] && index == IDX_ACTIVATE) begin
          dev_on[gi] <= isa_s2.data[ACTIVATE_BIT];
        end else if (pwr_ctrl_wr[gi]) begin
          dev_on[gi] <= pwr_ctrl_wdata[gi];
        end
      end

      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          base_hi[gi] <= BASE_RST;
          base_lo[gi] <= BASE_RST;
        end else if (soft_reset) begin
          base_hi[gi] <= BASE_RST;
          base_lo[gi] <= BASE_RST;
        end else if (slot_onehot[gi] && HAS_BASE) begin
          if (index == IDX_BASE_HI) begin
            base_hi[gi] <= isa_s2.data;
          end
          if (index == IDX_BASE_LO) begin
            base_lo[gi] <= isa_s2.data;
          end
        end
      end

      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          irq0[gi] <= IRQ0_RST;
          dma[gi]  <= DMA_RST;
        end else if (soft_reset) begin
          irq0[gi] <= IRQ0_RST;
          dma[gi]  <= DMA_RST;
        end else if (slot_onehot[gi]) begin
          if (index == IDX_IRQ0) begin
            irq0[gi] <= isa_s2.data;
          end
          if (index == IDX_DMA && HAS_DMA) begin
            dma[gi] <= isa_s2.data;
          end
        end
      end

      if (HAS_BASE) begin : g_chk
        localparam logic [15:0] MAXB = (gi == SLOT_PARALLEL) ? BASE_MAX_PAR : BASE_MAX_8;
        localparam int          ALN  = (gi == SLOT_PARALLEL) ? ALIGN_4 : ALIGN_8;
        logic ext_w;
        logic epp_w;
        base_addr_check #(
          .MAX_BASE (MAXB),
          .ALIGN    (ALN),
          .HAS_EXT  (gi == SLOT_PARALLEL)
        ) u_chk (
          .base     ({base_hi[gi], base_lo[gi]}),
          .addr     (isa_s2.addr),
          .qual16   (qual16_en),
          .valid    (chk_valid[gi]),
          .hit      (chk_hit[gi]),
          .ext_hit  (ext_w),
          .epp_ok   (epp_w)
        );
        if (gi == SLOT_PARALLEL) begin : g_par
          assign chk_ext = ext_w;
          assign chk_epp = epp_w;
        end
      end else begin : g_fixed
        assign chk_valid[gi] = 1'b0;
        assign chk_hit[gi]   = 1'b0;
      end
    end
  endgenerate

  // Only the keyboard bank carries the second interrupt select
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq1 <= IRQ1_RST;
    end else if (soft_reset) begin
      irq1 <= IRQ1_RST;
    end else if (slot_onehot[SLOT_KEYBOARD] && index == IDX_IRQ1) begin
      irq1 <= isa_s2.data;
    end
  end

  // Read data for the data port; every index not listed reads zero
  always_comb begin
    next_rdata = READ_ZERO;
    if (index == IDX_LDN) begin
      next_rdata = ldn;
    end else if (slot_known && index >= IDX_BANK_LO) begin
      case (index)
        IDX_ACTIVATE: next_rdata = {7'h00, dev_on[slot]};
        IDX_BASE_HI:  next_rdata = (slot <= 3'(SLOT_SERIAL2)) ? base_hi[slot] : READ_ZERO;
        IDX_BASE_LO:  next_rdata = (slot <= 3'(SLOT_SERIAL2)) ? base_lo[slot] : READ_ZERO;
        IDX_IRQ0:     next_rdata = irq0[slot];
        IDX_IRQ1:     next_rdata = (slot == 3'(SLOT_KEYBOARD)) ? irq1 : READ_ZERO;
        IDX_DMA:      next_rdata = (slot == 3'(SLOT_FLOPPY) || slot == 3'(SLOT_PARALLEL))
                                   ? dma[slot] : READ_ZERO;
        default:      next_rdata = READ_ZERO;
      endcase
    end
  end

  // The data pins are driven only while a read of a configuration port is in progress
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      isa_data_out  <= READ_ZERO;
      isa_data_oe_n <= 1'b1;
    end else begin
      isa_data_out  <= hit_index ? index : next_rdata;
      isa_data_oe_n <= !(config_state && !isa_s2.ior_n && (hit_index || hit_data));
    end
  end

  // Device selects: an illegal base keeps the device deaf to host cycles
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dev_sel     <= 6'h00;
      par_ext_sel <= 1'b0;
    end else begin
      dev_sel     <= cyc_active ? (dev_on & chk_valid & chk_hit) : 6'h00;
      par_ext_sel <= cyc_active && dev_on[SLOT_PARALLEL]
                     && chk_valid[SLOT_PARALLEL] && chk_ext;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dev_active    <= 6'h00;
      dev_pwr_ctrl  <= 6'h00;
      base_valid    <= 6'h00;
      par_epp_avail <= 1'b0;
    end else begin
      dev_active    <= dev_on;
      dev_pwr_ctrl  <= dev_on;
      base_valid    <= chk_valid;
      par_epp_avail <= chk_valid[SLOT_PARALLEL] && chk_epp;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_level_sel  <= '0;
      kbd_irq2_sel   <= IRQ1_RST;
      floppy_dma_sel <= DMA_RST_OTHER;
      par_dma_sel    <= DMA_RST_OTHER;
    end else begin
      irq_level_sel  <= irq0;
      kbd_irq2_sel   <= irq1;
      floppy_dma_sel <= dma[SLOT_FLOPPY];
      par_dma_sel    <= dma[SLOT_PARALLEL];
    end
  end

  // Polarity is fixed; level-low routing is left to the individual devices
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_active_high <= 1'b1;
    end else begin
      irq_active_high <= 1'b1;
    end
  end

endmodule : logical_device_config_regs
`default_nettype wire
